// ---- rtl/dac_channel_function_config.sv ----
// Notes on behaviour
// - Clear drives the code to zero-scale when bit 15 is 0, mid-scale when 1.
// - Bit 14 low updates at once; high waits for strobe pin fall or trigger bit.
// - Broadcast writes reach a channel only while its bit 13 is set.
// - Phase field picks start phase 0, 120, 240 or 90 degrees.
// - Shape field: triangle, sawtooth, inverse sawtooth, sine, or 111 for off.
// - Bit 7 picks linear or logarithmic slew and the meaning of bits 6 to 0.
// - Linear step codes map to 1, 2, 3, 4, 6, 8, 16 and 32 LSB.
// - Interval code 0000 jumps straight to the bound; invalid for waveforms.
// - Linear interval codes set 4 us up to 5127.92 us per step.
// - Log mode moves between the two bounds in 3.125 percent steps.
// - Log step grows by 1/32 upward and shrinks by 1/32 downward.
// - With a zero lower bound the log slew starts from code 1.
// - Bits 6 to 4 set the log step time while rising.
// - Bits 3 to 1 set the log step time while falling.
// - Config words sit at 18h and 06h and reset to zero.
// - Over PMBus page FFh, commands E0h and D4h reach the config words.
// - Trigger bit 7 loads every deferred channel and reads back as zero.
`timescale 1ns/10ps
module dac_channel_function_config #(
  parameter int unsigned time_div = 1 // Divides every step count, 1 in silicon
) (
  input wire logic mclk, // 50 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input dac_func_pkg::reg_req_s req, // Register access request
  output logic [15:0] reg_rdata, // Read data, valid the cycle after rd
  input wire logic load_strobe, // Load strobe pin, acts on falling edge
  input wire logic [1:0] clear_req, // Per-channel clear pulse
  input wire logic [1:0] data_wr, // Per-channel data write pulse
  input wire logic bcast_wr, // Broadcast data write pulse
  input wire logic [11:0] data_code, // Data for data_wr and bcast_wr
  input dac_func_pkg::bound_s [1:0] bounds, // Upper and lower bound codes
  input wire logic [1:0] go_upper, // Start a move to the upper bound
  input wire logic [1:0] go_lower, // Start a move to the lower bound
  output logic [1:0][11:0] dac_code, // Present output code per channel
  output logic [1:0] busy // Slew or waveform in progress
);
  import dac_func_pkg::*;

  typedef struct packed {
    logic [15:0] cfg;
    logic [11:0] code;
    logic [11:0] pend;
    logic pend_v;
    mode_e mode;
    logic [11:0] target;
    logic [11:0] phase;
  } chan_s;

  typedef struct packed {
    chan_s [1:0] ch;
    logic [15:0] rdata;
    logic strobe_q;
  } state_s;

  state_s st;
  state_s next_st;

  logic [1:0] tick;
  logic [1:0] restart;
  logic [1:0] run;
  logic [1:0][19:0] cycles;
  logic [1:0][11:0] log_nxt;
  logic [1:0][11:0] step_target;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  // The step size, clear level, valid shapes and interval index live in functions so that the read path, the slew
  // path and the waveform path can never disagree on a bit position.

  // True when the request points at the given register on either access path
  function automatic logic hits(input reg_req_s r, input logic [7:0] direct,
                                input logic [7:0] pmb_cmd);
    if (r.pmbus) begin
      return (r.page == PMB_PAGE) && (r.addr == pmb_cmd);
    end
    return r.addr == direct;
  endfunction : hits

  // A shape code that really produces a waveform
  function automatic logic shape_ok(input logic [2:0] s);
    return (s == SHAPE_TRI) || (s == SHAPE_SAW) || (s == SHAPE_INV) ||
           (s == SHAPE_SINE);
  endfunction : shape_ok

  // Code increment for the linear step field, shared by slew and waveform
  function automatic logic [11:0] step_size(input logic [15:0] cfg);
    return LIN_STEP[cfg[STEP_LSB +: 3]];
  endfunction : step_size

  // Level that a clear forces onto a channel
  function automatic logic [11:0] clear_code(input logic [15:0] cfg);
    if (cfg[CLR_BIT]) begin
      return MID_CODE;
    end
    return ZERO_CODE;
  endfunction : clear_code

  // Read mux: only the two config words read back, everything else is zero
  function automatic logic [15:0] read_word(input logic [1:0] hit, input logic [15:0] w0,
                                            input logic [15:0] w1);
    if (hit[0]) begin
      return w0;
    end
    if (hit[1]) begin
      return w1;
    end
    // The trigger register and unmapped addresses never echo anything back
    return READ_ZERO;
  endfunction : read_word

  // Interval code in the linear table for the present mode and direction
  function automatic logic [3:0] intv_index(input logic [15:0] cfg, input logic rising);
    if (cfg[LOG_BIT]) begin
      // Log codes are the odd entries of the linear table
      return rising ? {cfg[RISE_LSB +: 3], 1'b1} : {cfg[FALL_LSB +: 3], 1'b1};
    end
    return cfg[INTV_LSB +: 4];
  endfunction : intv_index

  // One linear step toward the target, stopping on it
  function automatic logic [11:0] lin_next(input logic [11:0] cur, input logic [11:0] tgt,
                                           input logic [11:0] step);
    if (tgt > cur) begin
      return (tgt - cur <= step) ? tgt : cur + step;
    end
    return (cur - tgt <= step) ? tgt : cur - step;
  endfunction : lin_next

  // Waveform sample between the bounds; sine is a parabolic approximation,
  // which keeps the area small at the cost of some harmonic content
  function automatic logic [11:0] wave_of(input logic [2:0] shape, input logic [11:0] ph,
                                          input bound_s b);
    logic [7:0] p;
    logic [7:0] w;
    logic [6:0] x;
    logic [13:0] par;
    logic [11:0] span;
    logic [19:0] prod;
    p = ph[11:4];
    x = p[6:0];
    // Widen before the product; a 7-bit product would wrap and flatten the curve
    par = 14'(x) * 14'(7'h7F - x);
    span = b.upper - b.lower;
    case (shape)
      SHAPE_SAW: w = p;
      SHAPE_INV: w = ~p;
      SHAPE_SINE: w = p[7] ? 8'h80 - 8'(par >> 5) : 8'h80 + 8'(par >> 5);
      default: w = p[7] ? ~{p[6:0], 1'b1} : {p[6:0], 1'b0};
    endcase
    prod = span * w;
    return b.lower + prod[19:8];
  endfunction : wave_of

  ////////////////////////////////////////////////////////////////////////////
  // Step timers and logarithmic step arithmetic, one of each per channel
  // The interval is looked up again every cycle, so a direction change picks
  // the matching rise or fall time without waiting for the next step.
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic rising;
    logic [19:0] raw;

    assign rising = st.ch[c].target > st.ch[c].code;
    assign raw = step_cycles(intv_index(st.ch[c].cfg, rising)) / 20'(time_div);
    assign cycles[c] = (raw == 20'h00000) ? 20'h00001 : raw;
    // Interval code zero never runs the timer, so a waveform stays parked
    assign run[c] = (st.ch[c].mode != M_IDLE) &&
                    (intv_index(st.ch[c].cfg, rising) != 4'h0);
    assign step_target[c] = st.ch[c].target;

    slew_step_timer u_timer (
      .mclk(mclk),
      .rst(rst),
      .run(run[c]),
      .restart(restart[c]),
      .cycles(cycles[c]),
      .tick(tick[c])
    );

    log_step_calc u_log (
      .cur(st.ch[c].code),
      .target(step_target[c]),
      .nxt(log_nxt[c])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic strobe_fall;
    logic sw_load;
    logic load_now;
    logic [1:0] cfg_hit;
    logic trig_hit;
    logic wr_data;
    logic [2:0] shape;
    chan_s cur;
    chan_s nc;
    strobe_fall = 1'b0;
    sw_load = 1'b0;
    load_now = 1'b0;
    cfg_hit = 2'b00;
    trig_hit = 1'b0;
    wr_data = 1'b0;
    shape = SHAPE_OFF;
    cur = '0;
    nc = '0;
    next_st = st;
    restart = 2'b00;

    cfg_hit[0] = hits(req, FCFG0_ADDR, PMB_FCFG0);
    cfg_hit[1] = hits(req, FCFG1_ADDR, PMB_FCFG1);
    trig_hit = hits(req, TRIG_ADDR, PMB_TRIG);

    // The pin is taken as synchronous; a falling edge is one of two load sources
    next_st.strobe_q = load_strobe;
    strobe_fall = st.strobe_q & ~load_strobe;
    // The trigger bit acts for one cycle only, so it always reads back as zero
    sw_load = req.wr && trig_hit && req.wdata[TRIG_LOAD_BIT];
    load_now = strobe_fall | sw_load;

    // Read data is captured one cycle after the request and then held,
    // so a slow host may pick it up at any time before its next read
    if (req.rd) begin
      next_st.rdata = read_word(cfg_hit, st.ch[0].cfg, st.ch[1].cfg);
    end

    for (int c = 0; c < 2; c++) begin
      cur = st.ch[c];
      nc = cur;

      // Configuration write, which may start or stop the waveform generator
      if (req.wr && cfg_hit[c]) begin
        nc.cfg = req.wdata;
        shape = req.wdata[SHAPE_LSB +: 3];
        restart[c] = 1'b1;
        if (shape_ok(shape)) begin
          nc.mode = M_WAVE;
          nc.phase = PHASE_OFS[req.wdata[PHASE_LSB +: 2]];
        end else if (cur.mode == M_WAVE) begin
          nc.mode = M_IDLE;
        end
      end

      // Step tick: advance the slew or the waveform
      if (tick[c]) begin
        if (cur.mode == M_SLEW) begin
          if (cur.cfg[LOG_BIT]) begin
            nc.code = log_nxt[c];
          end else begin
            nc.code = lin_next(cur.code, cur.target, step_size(cur.cfg));
          end
          if (nc.code == cur.target) begin
            nc.mode = M_IDLE;
          end
        end else if (cur.mode == M_WAVE && shape_ok(cur.cfg[SHAPE_LSB +: 3])) begin
          // Phase wraps on its own at 4096 points, so the shape repeats freely
          nc.phase = cur.phase + step_size(cur.cfg);
          nc.code = wave_of(cur.cfg[SHAPE_LSB +: 3], nc.phase, bounds[c]);
        end
      end

      // Start a move to one of the bounds
      // A move ends any running waveform; the two cannot share the code register.
      // With interval code zero the jump is immediate and no timer is started.
      if (go_upper[c] || go_lower[c]) begin
        nc.target = go_upper[c] ? bounds[c].upper : bounds[c].lower;
        restart[c] = 1'b1;
        if (!cur.cfg[LOG_BIT] && cur.cfg[INTV_LSB +: 4] == 4'h0) begin
          nc.code = nc.target;
          nc.mode = M_IDLE;
        end else begin
          nc.mode = M_SLEW;
          if (cur.cfg[LOG_BIT] && cur.code == ZERO_CODE) begin
            nc.code = LOG_FLOOR;
          end
        end
      end

      // Data writes, direct or broadcast
      // A closed channel ignores broadcasts entirely, pending data included
      wr_data = data_wr[c] | (bcast_wr & cur.cfg[BCAST_BIT]);
      if (wr_data) begin
        if (cur.cfg[DEFER_BIT]) begin
          nc.pend = data_code;
          nc.pend_v = 1'b1;
        end else begin
          nc.code = data_code;
          nc.mode = M_IDLE;
          nc.pend_v = 1'b0;
        end
      end

      // Deferred load; a write in the same cycle is loaded straight through
      if (load_now && cur.cfg[DEFER_BIT] && (nc.pend_v || wr_data)) begin
        nc.code = wr_data ? data_code : cur.pend;
        nc.pend_v = 1'b0;
        nc.mode = M_IDLE;
      end

      // Clear overrides every code and mode change in the cycle; a config write still lands
      // Pending deferred data is dropped, so a later strobe cannot undo the clear
      if (clear_req[c]) begin
        nc.code = clear_code(cur.cfg);
        nc.mode = M_IDLE;
        nc.pend_v = 1'b0;
      end

      next_st.ch[c] = nc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // The strobe history resets high, so a pin held low through reset
  // is taken as a falling edge on the first cycle after it.
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int c = 0; c < 2; c++) begin
        st.ch[c].cfg <= FCFG_RST;
        st.ch[c].code <= ZERO_CODE;
        st.ch[c].pend <= ZERO_CODE;
        st.ch[c].pend_v <= 1'b0;
        st.ch[c].mode <= M_IDLE;
        st.ch[c].target <= ZERO_CODE;
        st.ch[c].phase <= ZERO_CODE;
      end
      st.rdata <= READ_ZERO;
      st.strobe_q <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign reg_rdata = st.rdata;

  for (genvar c = 0; c < 2; c++) begin : g_out
    assign dac_code[c] = st.ch[c].code;
    assign busy[c] = st.ch[c].mode != M_IDLE;
  end

endmodule : dac_channel_function_config

// ---- rtl/dac_func_pkg.sv ----
package dac_func_pkg;

  // Register map, direct serial addresses
  localparam logic [7:0] FCFG0_ADDR = 8'h18;
  localparam logic [7:0] FCFG1_ADDR = 8'h06;
  localparam logic [7:0] TRIG_ADDR = 8'h20;
  // Register map, PMBus page and command codes
  localparam logic [7:0] PMB_PAGE = 8'hFF;
  localparam logic [7:0] PMB_FCFG0 = 8'hE0;
  localparam logic [7:0] PMB_FCFG1 = 8'hD4;
  localparam logic [7:0] PMB_TRIG = 8'hE4;
  localparam logic [15:0] FCFG_RST = 16'h0000;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // Field positions of the function configuration word
  localparam int CLR_BIT = 15;
  localparam int DEFER_BIT = 14;
  localparam int BCAST_BIT = 13;
  localparam int PHASE_LSB = 11;
  localparam int SHAPE_LSB = 8;
  localparam int LOG_BIT = 7;
  localparam int STEP_LSB = 4;
  localparam int INTV_LSB = 0;
  localparam int RISE_LSB = 4;
  localparam int FALL_LSB = 1;
  localparam int TRIG_LOAD_BIT = 7;

  // Codes
  localparam logic [11:0] ZERO_CODE = 12'h000;
  localparam logic [11:0] MID_CODE = 12'h800;
  localparam logic [11:0] LOG_FLOOR = 12'h001;
  localparam logic [2:0] SHAPE_TRI = 3'h0;
  localparam logic [2:0] SHAPE_SAW = 3'h1;
  localparam logic [2:0] SHAPE_INV = 3'h2;
  localparam logic [2:0] SHAPE_SINE = 3'h4;
  localparam logic [2:0] SHAPE_OFF = 3'h7;
  localparam int LOG_SHIFT = 5;
  localparam logic [7:0][11:0] LIN_STEP = {12'h020, 12'h010, 12'h008, 12'h006,
                                           12'h004, 12'h003, 12'h002, 12'h001};
  // Phase offsets of 0, 120, 240 and 90 degrees on a 4096-point cycle
  localparam logic [3:0][11:0] PHASE_OFS = {12'h400, 12'hAAB, 12'h555, 12'h000};

  // Step interval times in 10 ns units, index is the linear interval code
  localparam int CLK_PERIOD_NS = 20;
  localparam int TIME_UNIT_NS = 10;
  localparam int STEP_TIME [16] = '{0, 400, 800, 1200, 1800, 2704, 4048, 6072,
                                    9112, 13672, 23920, 41864, 73256, 128200,
                                    256396, 512792};

  typedef enum logic [1:0] {M_IDLE, M_SLEW, M_WAVE} mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic pmbus;
    logic [7:0] page;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [11:0] upper;
    logic [11:0] lower;
  } bound_s;

  // Cycles per step, truncated to whole clock periods
  function automatic logic [19:0] step_cycles(input logic [3:0] idx);
    int c;
    c = STEP_TIME[idx] * TIME_UNIT_NS / CLK_PERIOD_NS;
    return c[19:0];
  endfunction : step_cycles

endpackage : dac_func_pkg

// ---- rtl/slew_step_timer.sv ----
`timescale 1ns/10ps
module slew_step_timer (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic run, // Count while high
  input wire logic restart, // Start a fresh interval
  input wire logic [19:0] cycles, // Interval length in clocks
  output logic tick // One-cycle step enable
);
  import dac_func_pkg::*;

  typedef struct packed {
    logic [19:0] cnt;
    logic tick;
  } tmr_s;

  tmr_s st;
  tmr_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Divider from the system clock down to the step rate
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run || restart) begin
      next_st.cnt = 20'h00000;
    end else if (st.cnt + 20'h00001 >= cycles) begin
      next_st.cnt = 20'h00000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 20'h00001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

endmodule : slew_step_timer

// ---- rtl/log_step_calc.sv ----
`timescale 1ns/10ps
module log_step_calc (
  input wire logic [11:0] cur, // Present code
  input wire logic [11:0] target, // Bound being approached
  output logic [11:0] nxt // Next code
);
  import dac_func_pkg::*;

  logic [12:0] up_sum;
  logic [11:0] delta;

  ////////////////////////////////////////////////////////////////////////////
  // Geometric step of 1/32 of the present code, never less than one LSB
  always_comb begin
    delta = cur >> LOG_SHIFT;
    if (delta == 12'h000) begin
      delta = 12'h001;
    end
    up_sum = {1'b0, cur} + {1'b0, delta};
    if (target > cur) begin
      nxt = (up_sum >= {1'b0, target}) ? target : up_sum[11:0];
    end else if (cur - target <= delta) begin
      nxt = target;
    end else begin
      nxt = cur - delta;
    end
  end

endmodule : log_step_calc

// ---- tb/dac_func_asserts.sv ----
`timescale 1ns/10ps
module dac_func_asserts (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input dac_func_pkg::reg_req_s req, // Register request
  input wire logic [15:0] reg_rdata, // Read data
  input wire logic load_strobe, // Load pin
  input wire logic [1:0] clear_req, // Clear pulses
  input wire logic [1:0] data_wr, // Data writes
  input wire logic bcast_wr, // Broadcast write
  input wire logic [11:0] data_code, // Data
  input dac_func_pkg::bound_s [1:0] bounds, // Bound codes
  input wire logic [1:0] go_upper, // Move up
  input wire logic [1:0] go_lower, // Move down
  input wire logic [1:0][11:0] dac_code, // Output codes
  input wire logic [1:0] busy // Activity
);
  import dac_func_pkg::*;
  logic hit0;
  logic [15:0] c0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  //////////////////////////////
  // Shadow of the channel 0 word, so checks can follow its fields
  assign hit0 = req.wr && ((!req.pmbus && req.addr == FCFG0_ADDR) ||
                (req.pmbus && req.page == PMB_PAGE && req.addr == PMB_FCFG0));
  always_ff @(posedge mclk) begin
    if (rst) begin
      c0 <= FCFG_RST;
    end else if (hit0) begin
      c0 <= req.wdata;
    end
  end
  //////////////////////////////
  // Write then read of the same word
  sequence s_wr_rd0;
    hit0 ##2 (req.rd && !req.wr && !req.pmbus && req.addr == FCFG0_ADDR);
  endsequence
  AST_RESET: assert property (disable iff (1'b0) rst |=>
    dac_code == '0 && busy == '0 && reg_rdata == READ_ZERO) else $error("reset state wrong");
  AST_READBACK: assert property (s_wr_rd0 |=> reg_rdata == $past(req.wdata, 3))
    else $error("config word read back wrong");
  AST_UNMAPPED: assert property (req.rd && !req.pmbus && req.addr != FCFG0_ADDR &&
    req.addr != FCFG1_ADDR |=> reg_rdata == READ_ZERO) else $error("unmapped read not zero");
  AST_CLEAR: assert property (clear_req[0] && !hit0 |=>
    dac_code[0] == ($past(c0[CLR_BIT]) ? MID_CODE : ZERO_CODE) && !busy[0])
    else $error("clear level wrong");
  AST_IMMED: assert property (data_wr[0] && !c0[DEFER_BIT] && !clear_req[0] |=>
    dac_code[0] == $past(data_code)) else $error("immediate update missing");
  AST_BCAST_OFF: assert property (bcast_wr && !c0[BCAST_BIT] && !c0[DEFER_BIT] &&
    !hit0 && !clear_req[0] && !data_wr[0] && !go_upper[0] && !go_lower[0] && !busy[0]
    |=> $stable(dac_code[0])) else $error("broadcast reached a closed channel");
  AST_NO_SLEW: assert property (go_upper[0] && !c0[LOG_BIT] && c0[3:0] == 4'h0 &&
    !c0[DEFER_BIT] && !clear_req[0] && !data_wr[0] && !bcast_wr
    |=> dac_code[0] == $past(bounds[0].upper)) else $error("unslewed move wrong");
  AST_LIN_STEP: assert property (!c0[LOG_BIT] && c0[10:8] == SHAPE_OFF &&
    $past(busy[0]) && busy[0] && dac_code[0] > $past(dac_code[0])
    |-> dac_code[0] - $past(dac_code[0]) == LIN_STEP[c0[6:4]]) else $error("linear step wrong");
endmodule : dac_func_asserts

// ---- tb/host_model.sv ----
`timescale 1ns/10ps
module host_model (
  input wire logic mclk, // Clock
  output dac_func_pkg::reg_req_s req, // Request to the block
  input wire logic [15:0] reg_rdata // Read data
);
  import dac_func_pkg::*;
  initial req = '0;
  //////////////////////////////
  // One-cycle write; released fields are inverted so stale values never match
  task automatic wr(input logic pm, input logic [7:0] pg, input logic [7:0] a,
                    input logic [15:0] d);
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, pmbus: pm, page: pg, addr: a, wdata: d};
    @(negedge mclk);
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask : wr
  // One-cycle read; data is taken once the answer has settled
  task automatic rd(input logic pm, input logic [7:0] pg, input logic [7:0] a,
                    output logic [15:0] q);
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, pmbus: pm, page: pg, addr: a, wdata: 16'h0000};
    @(negedge mclk);
    req.rd = 1'b0;
    req.addr = ~a;
    q = reg_rdata;
  endtask : rd
endmodule : host_model

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  import dac_func_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  reg_req_s req;
  logic [15:0] reg_rdata, rv;
  logic load_strobe = 1'b1;
  logic [1:0] clear_req = '0, data_wr = '0, go_upper = '0, go_lower = '0, busy;
  logic bcast_wr = 1'b0;
  logic [11:0] data_code = '0;
  bound_s [1:0] bounds = '0;
  logic [1:0][11:0] dac_code;
  int error_cnt = 0;
  int compares = 0;
  always #10 mclk = ~mclk;
  host_model host (.mclk, .req, .reg_rdata);
  // Step counts shortened by 64 to keep slews brief
  dac_channel_function_config #(.time_div(64)) DUT (.mclk, .rst, .req, .reg_rdata,
    .load_strobe, .clear_req, .data_wr, .bcast_wr, .data_code, .bounds, .go_upper,
    .go_lower, .dac_code, .busy);
  //////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic cfg0(input logic [15:0] d);
    host.wr(1'b0, 8'h00, FCFG0_ADDR, d);
  endtask : cfg0
  task automatic pulse(input logic [1:0] ch, input logic bc, input logic [1:0] clr,
                       input logic [11:0] code);
    @(negedge mclk);
    data_wr = ch;
    bcast_wr = bc;
    clear_req = clr;
    data_code = code;
    @(negedge mclk);
    data_wr = '0;
    bcast_wr = 1'b0;
    clear_req = '0;
    data_code = ~code;
  endtask : pulse
  task automatic go(input logic up);
    @(negedge mclk);
    go_upper[0] = up;
    go_lower[0] = !up;
    @(negedge mclk);
    go_upper = '0;
    go_lower = '0;
  endtask : go
  // Follows channel 0 step by step; a lost slew is cut short after 4000 cycles
  task automatic watch(input logic lg, input logic up, input logic [11:0] sz);
    logic [11:0] cur, nx, tgt, st;
    int n;
    cur = dac_code[0];
    tgt = up ? bounds[0].upper : bounds[0].lower;
    n = 0;
    while (dac_code[0] !== tgt && n < 4000) begin
      @(negedge mclk);
      n++;
      if (dac_code[0] !== cur) begin
        st = lg ? (((cur >> 5) != 12'h000) ? (cur >> 5) : 12'h001) : sz;
        if (up) nx = (lg && cur == 12'h000) ? 12'h001 : ((tgt - cur > st) ? cur + st : tgt);
        else nx = (cur - tgt > st) ? cur - st : tgt;
        check(dac_code[0], nx);
        cur = dac_code[0];
      end
    end
    if (n >= 4000) begin
      error_cnt++;
      $display("MISMATCH %0t slew never reached its bound", $time);
      wrap_up();
    end
    check(busy[0], 1'b0);
  endtask : watch
  //////////////////////////////
  task automatic t_regs();
    host.rd(1'b0, 8'h00, FCFG0_ADDR, rv);
    check(rv, 16'h0000);
    host.rd(1'b1, PMB_PAGE, PMB_FCFG1, rv);
    check(rv, 16'h0000);
    cfg0(16'hA7C3);
    host.rd(1'b0, 8'h00, FCFG0_ADDR, rv);
    check(rv, 16'hA7C3);
    host.wr(1'b1, PMB_PAGE, PMB_FCFG1, 16'h67F5);
    host.wr(1'b1, 8'h03, PMB_FCFG0, 16'h1234);
    host.rd(1'b1, PMB_PAGE, PMB_FCFG0, rv);
    check(rv, 16'hA7C3);
    host.rd(1'b0, 8'h00, FCFG1_ADDR, rv);
    check(rv, 16'h67F5);
    host.rd(1'b0, 8'h00, 8'h07, rv);
    check(rv, 16'h0000);
    host.rd(1'b1, 8'h03, PMB_FCFG0, rv);
    check(rv, 16'h0000);
  endtask : t_regs
  task automatic t_clear();
    cfg0(16'h8700);
    pulse(2'b01, 1'b0, 2'b00, 12'h123);
    pulse(2'b00, 1'b0, 2'b01, 12'h000);
    check(dac_code[0], 12'h800);
    cfg0(16'h0700);
    pulse(2'b00, 1'b0, 2'b01, 12'h000);
    check(dac_code[0], 12'h000);
  endtask : t_clear
  task automatic t_defer();
    cfg0(16'h4700);
    pulse(2'b01, 1'b0, 2'b00, 12'h155);
    cyc(2);
    check(dac_code[0], 12'h000);
    load_strobe = 1'b0;
    cyc(2);
    check(dac_code[0], 12'h155);
    load_strobe = 1'b1;
    pulse(2'b01, 1'b0, 2'b00, 12'h2AA);
    cyc(1);
    check(dac_code[0], 12'h155);
    host.wr(1'b0, 8'h00, TRIG_ADDR, 16'h0080);
    cyc(1);
    check(dac_code[0], 12'h2AA);
    host.rd(1'b1, PMB_PAGE, PMB_TRIG, rv);
    check(rv, 16'h0000);
  endtask : t_defer
  task automatic t_bcast();
    cfg0(16'h0700);
    host.wr(1'b1, PMB_PAGE, PMB_FCFG1, 16'h2700);
    pulse(2'b00, 1'b1, 2'b00, 12'h3AB);
    cyc(1);
    check(dac_code[0], 12'h2AA);
    check(dac_code[1], 12'h3AB);
    cfg0(16'h2700);
    pulse(2'b00, 1'b1, 2'b00, 12'h0CD);
    cyc(1);
    check(dac_code[0], 12'h0CD);
  endtask : t_bcast
  task automatic t_lin();
    logic [11:0] sz [8] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h006, 12'h008,
                            12'h010, 12'h020};
    bounds[0] = '{upper: 12'h03F, lower: 12'h010};
    for (int k = 0; k < 8; k++) begin
      cfg0(16'h0701 | (16'(k) << 4));
      pulse(2'b01, 1'b0, 2'b00, 12'h010);
      go(1'b1);
      watch(1'b0, 1'b1, sz[k]);
    end
    go(1'b0);
    watch(1'b0, 1'b0, sz[7]);
    cfg0(16'h0700);
    go(1'b1);
    cyc(1);
    check(dac_code[0], 12'h03F);
  endtask : t_lin
  task automatic t_log();
    cfg0(16'h0792);
    bounds[0] = '{upper: 12'h050, lower: 12'h000};
    pulse(2'b01, 1'b0, 2'b00, 12'h000);
    go(1'b1);
    check(dac_code[0], 12'h001);
    watch(1'b1, 1'b1, 12'h000);
    bounds[0].lower = 12'h010;
    go(1'b0);
    watch(1'b1, 1'b0, 12'h000);
  endtask : t_log
  // Every valid shape starts, then a stop or invalid code freezes the output
  task automatic t_wave();
    logic [2:0] shp [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    logic [2:0] stp [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    logic [11:0] first [3] = '{12'h100, 12'h155, 12'h155};
    logic [11:0] held;
    bounds[0] = '{upper: 12'h200, lower: 12'h100};
    for (int k = 0; k < 4; k++) begin
      cfg0({3'b000, 2'(k), shp[k], 8'h01});
      cyc(3);
      check(busy[0], 1'b1);
      cyc(1);
      if (k < 3) check(dac_code[0], first[k]);
      cfg0({5'b00000, stp[k], 8'h01});
      cyc(1);
      held = dac_code[0];
      cyc(10);
      check(dac_code[0], held);
      check(busy[0], 1'b0);
    end
  endtask : t_wave
  //////////////////////////////
  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    t_regs();
    t_clear();
    t_defer();
    t_bcast();
    t_lin();
    t_log();
    t_wave();
    wrap_up();
  end
endmodule : tb
bind dac_channel_function_config dac_func_asserts chk (.mclk, .rst, .req, .reg_rdata,
  .load_strobe, .clear_req, .data_wr, .bcast_wr, .data_code, .bounds, .go_upper,
  .go_lower, .dac_code, .busy);
